// ---- rtl/pts_switch.sv ----
// Packet switch fabric: ingress queues, routing, egress arbitration, FIFO.
// Assumes ports driven by logic on clk; only the strap pin and reset_n are asynchronous.

`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Synchronous FIFO
// ---------------------------------------------------------------
module pts_fifo #(
  parameter int unsigned W  = 8,
  parameter int unsigned D  = 8,
  parameter int unsigned CW = $clog2(D + 1)
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Fill side
  input  wire logic          in_valid,
  output wire logic          in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side
  output wire logic          out_valid,
  input  wire logic          out_ready,
  output wire logic [W-1:0]  out_data,
  // Free entries
  output wire logic [CW-1:0] free
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic          do_wr;
  logic          do_rd;

  assign in_ready  = (count_reg != CW'(D));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign free      = CW'(D) - count_reg;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      if (do_wr && !do_rd)
        count_reg <= count_reg + 1'b1;
      else if (do_rd && !do_wr)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule : pts_fifo

// ---------------------------------------------------------------
// Switch top
// ---------------------------------------------------------------
module pts_switch #(
  parameter int unsigned DW  = pts_pkg::PTS_DW,
  parameter int unsigned QD  = pts_pkg::PTS_QDEPTH,
  parameter int unsigned CW  = $clog2(QD + 1),
  parameter int unsigned TOK = pts_pkg::PTS_ISO_TOKENS
) (
  // Clock and fundamental reset
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  // Ingress streams
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         rx_valid,
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         rx_sop,
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         rx_eop,
  input  wire logic [pts_pkg::PTS_NPORT-1:0][DW-1:0] rx_data,
  output wire logic [pts_pkg::PTS_NPORT-1:0]         rx_ready,
  // Egress streams
  output wire logic [pts_pkg::PTS_NPORT-1:0]         tx_valid,
  output wire logic [pts_pkg::PTS_NPORT-1:0]         tx_sop,
  output wire logic [pts_pkg::PTS_NPORT-1:0]         tx_eop,
  output wire logic [pts_pkg::PTS_NPORT-1:0][DW-1:0] tx_data,
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         tx_ready,
  // Credit advertisement
  output wire logic [pts_pkg::PTS_NPORT-1:0][CW-1:0] rx_credit_vc0,
  output wire logic [pts_pkg::PTS_NPORT-1:0][CW-1:0] rx_credit_vc1,
  // Enumeration and routing setup
  input  wire logic [pts_pkg::PTS_NPORT-1:0][15:0]   port_id,
  input  wire logic [pts_pkg::PTS_NPORT-1:0][7:0]    sec_bus,
  input  wire logic [pts_pkg::PTS_NPORT-1:0][7:0]    sub_bus,
  input  wire logic [pts_pkg::PTS_NPORT-1:0][31:0]   mem_base,
  input  wire logic [pts_pkg::PTS_NPORT-1:0][31:0]   mem_limit,
  // Channel mapping and access control
  input  wire logic [pts_pkg::PTS_NPORT-1:0][pts_pkg::PTS_NTC-1:0] tc_vc_map,
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         vc1_enable,
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         acs_p2p_en,
  input  wire logic [pts_pkg::PTS_NPORT-1:0]         acs_direct_xlat_en,
  // Power management
  input  wire pts_pkg::pts_dev_pwr_t                 dev_pwr_state,
  input  wire pts_pkg::pts_link_pwr_t                link_pwr_state
                                                     [pts_pkg::PTS_NPORT],
  output wire logic [pts_pkg::PTS_NPORT-1:0]         fwd_enabled,
  output wire logic                                  fabric_idle,
  // Reference clock buffer
  input  wire logic                                  clkbuf_disable_pin,
  output wire logic [pts_pkg::PTS_NREFCLK-1:0]       refclk_out_en
);
  import pts_pkg::*;

  localparam int unsigned QW = DW + 4;
  localparam int unsigned EW = DW + 2;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    addr_hit = (a >= lo) && (a <= hi);
  endfunction : addr_hit

  function automatic logic bus_hit(input logic [7:0] b,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    bus_hit = (b >= lo) && (b <= hi);
  endfunction : bus_hit

  function automatic logic [1:0] rr_next(input logic [1:0] last,
                                         input int unsigned step);
    int unsigned s;
    s = 32'(last) + step;
    rr_next = 2'(s % PTS_NPORT);
  endfunction : rr_next

  // ---------------------------------------------------------------
  // Shared nets
  // ---------------------------------------------------------------
  wire logic [PTS_NPORT-1:0] q0_ov;
  wire logic [PTS_NPORT-1:0] q1_ov;
  wire logic [QW-1:0]        q0_od [PTS_NPORT];
  wire logic [QW-1:0]        q1_od [PTS_NPORT];
  wire logic [PTS_NPORT-1:0] eg_take;
  wire logic [PTS_NPORT-1:0] eg_vc;
  wire logic [1:0]           eg_src [PTS_NPORT];
  wire logic [PTS_NPORT-1:0] eg_busy;
  logic      [PTS_NPORT-1:0] q0_pop;
  logic      [PTS_NPORT-1:0] q1_pop;
  logic      [PTS_NPORT-1:0] fwd_ok;
  logic                      slot_tick_reg;
  logic [15:0]               slot_cnt_reg;

  // ---------------------------------------------------------------
  // Power gating of forwarding
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < PTS_NPORT; p++)
      fwd_ok[p] = (dev_pwr_state == PTS_D0) &&
                  (link_pwr_state[p] == PTS_L0);
  end

  // ---------------------------------------------------------------
  // Isochronous slot divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slot_cnt_reg  <= '0;
      slot_tick_reg <= 1'b0;
    end
    else
    begin
      slot_tick_reg <= (slot_cnt_reg == 16'(PTS_ISO_SLOT_CYC - 1));
      slot_cnt_reg  <= (slot_cnt_reg == 16'(PTS_ISO_SLOT_CYC - 1))
                       ? '0 : slot_cnt_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Ingress ports
  // ---------------------------------------------------------------
  for (genvar i = 0; i < PTS_NPORT; i++)
  begin : g_in
    logic [1:0]    dest_new;
    logic          vc_new;
    logic [1:0]    dest_hold_reg;
    logic          vc_hold_reg;
    logic [1:0]    cur_dest;
    logic          cur_vc;
    logic          rdy_reg;
    logic [CW-1:0] cr0_reg;
    logic [CW-1:0] cr1_reg;
    logic [2:0]    tc;
    logic [PTS_NPORT-1:0] hit;
    wire logic          wr;
    wire logic [QW-1:0] word;
    wire logic          q0_iv;
    wire logic          q0_ir;
    wire logic [QW-1:0] q0_id;
    wire logic          q1_iv;
    wire logic          q1_ir;
    wire logic          q1_or;
    wire logic [CW-1:0] q0_free;
    wire logic [CW-1:0] q1_free;

    always_comb
    begin
      tc = rx_data[i][PTS_HDR_TC_LSB +: 3];
      for (int k = 0; k < PTS_NPORT; k++)
        hit[k] = rx_data[i][PTS_HDR_BYID_BIT]
          ? ((rx_data[i][PTS_HDR_TID_LSB +: 16] == port_id[k]) ||
             bus_hit(rx_data[i][PTS_HDR_TBUS_LSB +: 8],
                     sec_bus[k], sub_bus[k]))
          : addr_hit(rx_data[i][PTS_HDR_ADDR_LSB +: 32],
                     mem_base[k], mem_limit[k]);
      dest_new = PTS_DEST_NONE;
      if (i == 0)
      begin
        if (hit[1])
          dest_new = 2'h1;
        else if (hit[2])
          dest_new = 2'h2;
      end
      else if (!hit[i])
      begin
        dest_new = PTS_UP_PORT;
        if (hit[(3 - i) % 3] && (acs_p2p_en[i] ||
            (rx_data[i][PTS_HDR_XLAT_BIT] && acs_direct_xlat_en[i])))
          dest_new = 2'(3 - i);
      end
      vc_new = vc1_enable[i] && (tc != 3'h0) && tc_vc_map[i][tc];
    end

    assign cur_dest = rx_sop[i] ? dest_new : dest_hold_reg;
    assign cur_vc   = rx_sop[i] ? vc_new : vc_hold_reg;
    assign wr       = rx_valid[i] && rdy_reg && (cur_dest != PTS_DEST_NONE);
    assign word     = {cur_dest, rx_sop[i], rx_eop[i], rx_data[i]};

    assign q1_iv = wr && q1_ir && (cur_vc || !vc1_enable[i]);
    assign q0_iv = vc1_enable[i] ? (wr && !cur_vc) : q1_ov[i];
    assign q0_id = vc1_enable[i] ? word : q1_od[i];
    assign q1_or = vc1_enable[i] ? q1_pop[i] : q0_ir;

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        dest_hold_reg <= PTS_DEST_NONE;
        vc_hold_reg   <= 1'b0;
      end
      else if (rx_valid[i] && rdy_reg && rx_sop[i])
      begin
        dest_hold_reg <= dest_new;
        vc_hold_reg   <= vc_new;
      end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        rdy_reg <= 1'b0;
        cr0_reg <= '0;
        cr1_reg <= '0;
      end
      else
      begin
        rdy_reg <= fwd_ok[i] && (q0_free >= CW'(2)) && (q1_free >= CW'(2));
        cr0_reg <= q0_free;
        cr1_reg <= vc1_enable[i] ? q1_free : '0;
      end
    end

    assign rx_ready[i]      = rdy_reg;
    assign rx_credit_vc0[i] = cr0_reg;
    assign rx_credit_vc1[i] = cr1_reg;

    pts_fifo #(.W(QW), .D(QD), .CW(CW)) u_q0 (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (q0_iv),
      .in_ready  (q0_ir),
      .in_data   (q0_id),
      .out_valid (q0_ov[i]),
      .out_ready (q0_pop[i]),
      .out_data  (q0_od[i]),
      .free      (q0_free)
    );

    pts_fifo #(.W(QW), .D(QD), .CW(CW)) u_q1 (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (q1_iv),
      .in_ready  (q1_ir),
      .in_data   (word),
      .out_valid (q1_ov[i]),
      .out_ready (q1_or),
      .out_data  (q1_od[i]),
      .free      (q1_free)
    );
  end : g_in

  // ---------------------------------------------------------------
  // Queue pops from egress locks
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < PTS_NPORT; i++)
    begin
      q0_pop[i] = 1'b0;
      q1_pop[i] = 1'b0;
      for (int e = 0; e < PTS_NPORT; e++)
      begin
        if (eg_take[e] && (eg_src[e] == 2'(i)) && !eg_vc[e])
          q0_pop[i] = 1'b1;
        if (eg_take[e] && (eg_src[e] == 2'(i)) && eg_vc[e])
          q1_pop[i] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Egress ports
  // ---------------------------------------------------------------
  for (genvar e = 0; e < PTS_NPORT; e++)
  begin : g_eg
    pts_eg_state_t state_reg;
    logic [1:0]    src_reg;
    logic          vc_reg;
    logic [1:0]    rr_reg;
    logic [3:0]    tok_reg;
    logic          c1;
    logic          c0;
    logic [1:0]    c1_src;
    logic [1:0]    c0_src;
    logic [1:0]    idx;
    logic          grant;
    logic          grant_vc;
    logic          tv_reg;
    logic          ts_reg;
    logic          te_reg;
    logic [DW-1:0] td_reg;
    wire logic          hv;
    wire logic [QW-1:0] hw;
    wire logic          ei_r;
    wire logic          eo_v;
    wire logic          eo_r;
    wire logic [EW-1:0] eo_d;

    always_comb
    begin
      c1     = 1'b0;
      c0     = 1'b0;
      c1_src = '0;
      c0_src = '0;
      idx    = '0;
      for (int k = 1; k <= PTS_NPORT; k++)
      begin
        idx = rr_next(rr_reg, k);
        if (!c1 && q1_ov[idx] && vc1_enable[idx] && q1_od[idx][DW+1] &&
            (q1_od[idx][DW+3:DW+2] == 2'(e)))
        begin
          c1     = 1'b1;
          c1_src = idx;
        end
        if (!c0 && q0_ov[idx] && q0_od[idx][DW+1] &&
            (q0_od[idx][DW+3:DW+2] == 2'(e)))
        begin
          c0     = 1'b1;
          c0_src = idx;
        end
      end
      grant    = (state_reg == PTS_EG_IDLE) && fwd_ok[e] &&
                 ((c1 && (tok_reg != '0)) || c0);
      grant_vc = c1 && (tok_reg != '0);
    end

    assign hv          = vc_reg ? q1_ov[src_reg] : q0_ov[src_reg];
    assign hw          = vc_reg ? q1_od[src_reg] : q0_od[src_reg];
    assign eg_take[e]  = (state_reg == PTS_EG_MOVE) && hv && ei_r;
    assign eg_src[e]   = src_reg;
    assign eg_vc[e]    = vc_reg;
    assign eg_busy[e]  = (state_reg == PTS_EG_MOVE) || eo_v || tv_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        state_reg <= PTS_EG_IDLE;
        src_reg   <= '0;
        vc_reg    <= 1'b0;
        rr_reg    <= PTS_RR_RST;
      end
      else
      begin
        unique case (state_reg)
          PTS_EG_IDLE:
            if (grant)
            begin
              state_reg <= PTS_EG_MOVE;
              vc_reg    <= grant_vc;
              src_reg   <= grant_vc ? c1_src : c0_src;
              rr_reg    <= grant_vc ? c1_src : c0_src;
            end
          PTS_EG_MOVE:
            if (eg_take[e] && hw[DW])
              state_reg <= PTS_EG_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        tok_reg <= PTS_TOK_RST;
      else if (slot_tick_reg)
        tok_reg <= 4'(TOK);
      else if (grant && grant_vc)
        tok_reg <= tok_reg - 4'h1;
    end

    pts_fifo #(.W(EW), .D(QD), .CW(CW)) u_replay (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (eg_take[e]),
      .in_ready  (ei_r),
      .in_data   (hw[EW-1:0]),
      .out_valid (eo_v),
      .out_ready (eo_r),
      .out_data  (eo_d),
      .free      ()
    );

    assign eo_r = !tv_reg || tx_ready[e];

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        tv_reg <= 1'b0;
        ts_reg <= 1'b0;
        te_reg <= 1'b0;
        td_reg <= '0;
      end
      else if (eo_r)
      begin
        tv_reg <= eo_v;
        ts_reg <= eo_d[DW+1];
        te_reg <= eo_d[DW];
        td_reg <= eo_d[DW-1:0];
      end
    end

    assign tx_valid[e] = tv_reg;
    assign tx_sop[e]   = ts_reg;
    assign tx_eop[e]   = te_reg;
    assign tx_data[e]  = td_reg;
  end : g_eg

  // ---------------------------------------------------------------
  // Status, idle report and clock buffer strap
  // ---------------------------------------------------------------
  logic                      idle_reg;
  logic [PTS_NPORT-1:0]      fwd_reg;
  logic                      strap_meta_reg;
  logic                      strap_sync_reg;
  logic [PTS_NREFCLK-1:0]    refclk_en_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_reg <= 1'b0;
      fwd_reg  <= '0;
    end
    else
    begin
      idle_reg <= (q0_ov == '0) && (q1_ov == '0) && (eg_busy == '0);
      fwd_reg  <= fwd_ok;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_meta_reg <= 1'b1;
      strap_sync_reg <= 1'b1;
      refclk_en_reg  <= '0;
    end
    else
    begin
      strap_meta_reg <= clkbuf_disable_pin;
      strap_sync_reg <= strap_meta_reg;
      refclk_en_reg  <= {PTS_NREFCLK{!strap_sync_reg}};
    end
  end

  assign fabric_idle   = idle_reg;
  assign fwd_enabled   = fwd_reg;
  assign refclk_out_en = refclk_en_reg;

endmodule : pts_switch

`default_nettype wire

// ---- rtl/pts_pkg.sv ----
// Constants, encodings and types of the three-port packet switch fabric.
// Assumes one 50 MHz clock and an asynchronous active-low reset.

package pts_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned PTS_NPORT    = 3;
  localparam int unsigned PTS_NVC      = 2;
  localparam int unsigned PTS_NTC      = 8;
  localparam int unsigned PTS_DW       = 64;
  localparam int unsigned PTS_QDEPTH   = 8;
  localparam int unsigned PTS_NREFCLK  = 7;

  // ---------------------------------------------------------------
  // Header word fields
  // ---------------------------------------------------------------
  localparam int unsigned PTS_HDR_TC_LSB    = 2;
  localparam int unsigned PTS_HDR_BYID_BIT  = 5;
  localparam int unsigned PTS_HDR_XLAT_BIT  = 6;
  localparam int unsigned PTS_HDR_REQID_LSB = 16;
  localparam int unsigned PTS_HDR_ADDR_LSB  = 32;
  localparam int unsigned PTS_HDR_TID_LSB   = 48;
  localparam int unsigned PTS_HDR_TBUS_LSB  = 56;

  // ---------------------------------------------------------------
  // Ports, reset values, timing
  // ---------------------------------------------------------------
  localparam logic [1:0] PTS_UP_PORT   = 2'h0;
  localparam logic [1:0] PTS_DEST_NONE = 2'h3;
  localparam logic [1:0] PTS_RR_RST    = 2'h0;
  localparam logic [3:0] PTS_TOK_RST   = 4'h0;
  localparam int unsigned PTS_CLK_NS      = 20;
  localparam int unsigned PTS_ISO_SLOT_NS = 1000;
  localparam int unsigned PTS_ISO_SLOT_CYC =
    (PTS_ISO_SLOT_NS / PTS_CLK_NS) < 1 ? 1 : PTS_ISO_SLOT_NS / PTS_CLK_NS;
  localparam int unsigned PTS_ISO_TOKENS = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PTS_L0, PTS_L0S, PTS_L1, PTS_L1_1, PTS_L2L3_RDY, PTS_L2L3, PTS_L2L3_DEV
  } pts_link_pwr_t;

  typedef enum logic [2:0] {
    PTS_D0, PTS_D1, PTS_D2, PTS_D3_HOT, PTS_D3_COLD
  } pts_dev_pwr_t;

  typedef enum logic {
    PTS_EG_IDLE, PTS_EG_MOVE
  } pts_eg_state_t;

endpackage : pts_pkg

// ---- sim/pts_switch_asserts.sv ----
// Checker for the switch top: egress framing, credits, power, strap.
// Assumes binding into pts_switch; one clock, asynchronous reset_n.
`timescale 1ns/1ps
`default_nettype none
module pts_switch_asserts #(
  parameter int unsigned DW = 64,
  parameter int unsigned QD = 8,
  parameter int unsigned CW = 4
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   reset_n,
  // Streams
  input wire logic [2:0]             rx_ready,
  input wire logic [2:0]             tx_valid,
  input wire logic [2:0]             tx_sop,
  input wire logic [2:0]             tx_eop,
  input wire logic [2:0][DW-1:0]     tx_data,
  input wire logic [2:0]             tx_ready,
  // Credits and channels
  input wire logic [2:0][CW-1:0]     rx_credit_vc0,
  input wire logic [2:0][CW-1:0]     rx_credit_vc1,
  input wire logic [2:0]             vc1_enable,
  // Power and strap
  input wire pts_pkg::pts_dev_pwr_t  dev_pwr_state,
  input wire pts_pkg::pts_link_pwr_t link_pwr_state [3],
  input wire logic [2:0]             fwd_enabled,
  input wire logic                   fabric_idle,
  input wire logic                   clkbuf_disable_pin,
  input wire logic [6:0]             refclk_out_en
);
  import pts_pkg::*;
  logic open_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      open_reg <= 1'b0;
    else if (tx_valid[0] && tx_ready[0])
      open_reg <= !tx_eop[0];
  sequence stall_s;
    tx_valid[0] && !tx_ready[0];
  endsequence
  sequence held_s;
    tx_valid[0] && $stable(tx_data[0]) && $stable(tx_eop[0]);
  endsequence
  tx_hold_a: assert property (stall_s |=> held_s)
    else $error("egress word changed under stall");
  pkt_frame_a: assert property (tx_valid[0] |-> tx_sop[0] == !open_reg)
    else $error("egress start flag out of frame");
  credit_cap_a: assert property (rx_credit_vc0[1] <= QD)
    else $error("credit above queue depth");
  vc1_off_a: assert property ((!vc1_enable[1]) [*2] |->
    rx_credit_vc1[1] == '0) else $error("credit on disabled channel");
  dev_off_a: assert property ((dev_pwr_state != PTS_D0) [*2] |->
    rx_ready == '0 && fwd_enabled == '0) else $error("traffic off D0");
  link_off_a: assert property ((link_pwr_state[2] != PTS_L0) [*2] |->
    !fwd_enabled[2] && !rx_ready[2]) else $error("traffic off L0");
  fwd_on_a: assert property ((dev_pwr_state == PTS_D0 &&
    link_pwr_state[0] == PTS_L0) [*2] |-> fwd_enabled[0])
    else $error("forwarding not enabled");
  clk_off_a: assert property (clkbuf_disable_pin [*5] |->
    refclk_out_en == '0) else $error("clock outputs while disabled");
  clk_on_a: assert property ((!clkbuf_disable_pin) [*5] |->
    refclk_out_en == 7'h7F) else $error("clock outputs missing");
  idle_busy_a: assert property (tx_valid != '0 |-> !fabric_idle)
    else $error("idle while egress busy");
endmodule : pts_switch_asserts
bind pts_switch pts_switch_asserts #(.DW(DW), .QD(QD), .CW(CW))
  i_pts_switch_asserts (.clk, .reset_n, .rx_ready, .tx_valid, .tx_sop,
  .tx_eop, .tx_data, .tx_ready, .rx_credit_vc0, .rx_credit_vc1,
  .vc1_enable, .dev_pwr_state, .link_pwr_state, .fwd_enabled,
  .fabric_idle, .clkbuf_disable_pin, .refclk_out_en);
`default_nettype wire

// ---- sim/pts_sink_model.sv ----
// Link partners on the three egress streams: accept, pace or stall.
// Assumes the bench drives hold and slow just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pts_sink_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Pacing
  input  wire logic [2:0] hold,
  input  wire logic       slow,
  // Egress handshake
  output wire logic [2:0] tx_ready
);
  logic [2:0] ready_reg;
  assign tx_ready = ready_reg;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      ready_reg <= 3'h0;
    else
      ready_reg <= ~hold & (slow ? ~ready_reg : 3'h7);
endmodule : pts_sink_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Bench top: drives all ingress ports, collects every egress port.
// Assumes pts_switch, the sink model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pts_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, slow = 1'b1, clkbuf_disable_pin = 1'b0;
  logic [2:0] rx_valid = '0, rx_sop = '0, rx_eop = '0, hold = '0;
  logic [2:0] vc1_enable = '0, acs_p2p_en = '0, acs_direct_xlat_en = '0;
  logic [2:0] rx_ready, tx_valid, tx_sop, tx_eop, tx_ready, fwd_enabled;
  logic fabric_idle;
  logic [6:0] refclk_out_en;
  logic [2:0][63:0] rx_data = '0, tx_data;
  logic [2:0][3:0] rx_credit_vc0, rx_credit_vc1;
  logic [2:0][7:0] tc_vc_map = '0, sec_bus = {8'h03, 8'h02, 8'h01};
  logic [2:0][7:0] sub_bus = {8'h03, 8'h02, 8'h01};
  logic [2:0][15:0] port_id = {16'h0300, 16'h0200, 16'h0100};
  logic [2:0][31:0] mem_base = {32'h2000_0000, 32'h1000_0000, 32'h0};
  logic [2:0][31:0] mem_limit = {32'h2FFF_FFFF, 32'h1FFF_FFFF, 32'h0FFF_FFFF};
  pts_dev_pwr_t dev_pwr_state = PTS_D0;
  pts_link_pwr_t link_pwr_state [3] = '{PTS_L0, PTS_L0, PTS_L0};
  logic [65:0] got [3][$];
  int err_count = 0, cmp_count = 0;
  pts_switch i_pts_switch (.clk, .reset_n, .rx_valid, .rx_sop, .rx_eop,
    .rx_data, .rx_ready, .tx_valid, .tx_sop, .tx_eop, .tx_data, .tx_ready,
    .rx_credit_vc0, .rx_credit_vc1, .port_id, .sec_bus, .sub_bus, .mem_base,
    .mem_limit, .tc_vc_map, .vc1_enable, .acs_p2p_en, .acs_direct_xlat_en,
    .dev_pwr_state, .link_pwr_state, .fwd_enabled, .fabric_idle,
    .clkbuf_disable_pin, .refclk_out_en);
  pts_sink_model i_pts_sink_model (.clk, .reset_n, .hold, .slow, .tx_ready);
  always #10 clk = ~clk;
  always @(posedge clk)
    for (int p = 0; p < 3; p++)
      if (tx_valid[p] && tx_ready[p])
        got[p].push_back({tx_sop[p], tx_eop[p], tx_data[p]});
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [65:0] e, s);
    cmp_count++;
    if (e !== s)
    begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, e, s);
    end
  endtask : check
  function automatic logic [63:0] hdr(input logic [2:0] tc, input logic xl,
                                      input logic [31:0] a);
    return {a, 16'hA5C3, 9'h0, xl, a[31:24] == 8'h03, tc, 2'h0};
  endfunction : hdr
  task automatic send(input int p, n, input logic [63:0] h);
    for (int i = 0; i < n; i++)
    begin
      rx_valid[p] = 1'b1;
      rx_sop[p] = i == 0;
      rx_eop[p] = i == n - 1;
      rx_data[p] = h + 64'(i);
      for (int k = 0; rx_ready[p] !== 1'b1 && k < 300; k++)
        step();
      step();
    end
    rx_valid[p] = 1'b0;
  endtask : send
  task automatic await_pkt(input int p, n, input logic [63:0] h);
    logic [65:0] w;
    for (int k = 0; got[p].size() < n && k < 300; k++)
      step();
    for (int i = 0; i < n; i++)
    begin
      w = got[p].size() > 0 ? got[p].pop_front() : 'x;
      check($sformatf("port %0d word %0d", p, i),
            {i == 0, i == n - 1, h + 64'(i)}, w);
    end
  endtask : await_pkt
  task automatic t_routes;
    fork
      send(0, 1, hdr(3'h0, 1'b0, 32'h1000_0040));
      send(2, 3, hdr(3'h0, 1'b0, 32'h0500_0000));
    join
    await_pkt(1, 1, hdr(3'h0, 1'b0, 32'h1000_0040));
    await_pkt(0, 3, hdr(3'h0, 1'b0, 32'h0500_0000));
    send(0, 2, hdr(3'h0, 1'b0, 32'h0300_0000));
    await_pkt(2, 2, hdr(3'h0, 1'b0, 32'h0300_0000));
    for (int c = 0; c < 4; c++)
    begin
      acs_p2p_en[1] = c == 1;
      acs_direct_xlat_en[1] = c == 2;
      send(1, 1, hdr(3'h0, c >= 2, 32'h2000_0100));
      await_pkt(c == 1 || c == 2 ? 2 : 0, 1,
                hdr(3'h0, c >= 2, 32'h2000_0100));
    end
    check("vc1 credit off", 4'h0, rx_credit_vc1[2]);
  endtask : t_routes
  task automatic t_channels;
    tc_vc_map = {3{8'h20}};
    vc1_enable = 3'h7;
    for (int t = 0; t < 8; t++)
    begin
      send(1, 1, hdr(3'(t), 1'b0, 32'h0600_0000));
      await_pkt(0, 1, hdr(3'(t), 1'b0, 32'h0600_0000));
    end
    hold[0] = 1'b1;
    fork
      send(1, 1, hdr(3'h0, 1'b0, 32'h0700_0000));
      send(2, 1, hdr(3'h5, 1'b0, 32'h0700_0000));
    join
    hold[0] = 1'b0;
    await_pkt(0, 1, hdr(3'h5, 1'b0, 32'h0700_0000));
    await_pkt(0, 1, hdr(3'h0, 1'b0, 32'h0700_0000));
    check("vc1 credit", 4'h8, rx_credit_vc1[2]);
  endtask : t_channels
  task automatic t_fill;
    int n = 0;
    hold[0] = 1'b1;
    acs_p2p_en[2] = 1'b1;
    {rx_valid[1], rx_sop[1], rx_eop[1]} = 3'h7;
    while (rx_ready[1] === 1'b1 && n < 64)
    begin
      rx_data[1] = hdr(3'h0, 1'b0, 32'h0800_0000 + n);
      n++;
      step();
    end
    rx_valid[1] = 1'b0;
    check("refusal", 1'b1, n < 64);
    send(2, 1, hdr(3'h0, 1'b0, 32'h1000_0000));
    await_pkt(1, 1, hdr(3'h0, 1'b0, 32'h1000_0000));
    check("credit", 4'h8, rx_credit_vc0[2]);
    hold[0] = 1'b0;
    slow = 1'b0;
    for (int k = 0; k < n; k++)
      await_pkt(0, 1, hdr(3'h0, 1'b0, 32'h0800_0000 + k));
    step(8);
    check("idle", 1'b1, fabric_idle);
  endtask : t_fill
  task automatic t_power;
    for (int d = 1; d < 5; d++)
    begin
      dev_pwr_state = pts_dev_pwr_t'(d);
      step(3);
      check("device off", 6'h0, {rx_ready, fwd_enabled});
    end
    dev_pwr_state = PTS_D0;
    for (int l = 1; l < 8; l++)
    begin
      link_pwr_state[2] = l < 7 ? pts_link_pwr_t'(l) : PTS_L0;
      clkbuf_disable_pin = l < 7;
      step(5);
      check("link", l < 7 ? 13'h0D80 : 13'h1FFF,
            {rx_ready, fwd_enabled, refclk_out_en});
    end
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step(4);
    for (int p = 0; p < 3; p++)
      check("reset credit", 5'h18, {fabric_idle, rx_credit_vc0[p]});
  endtask : t_power
  task automatic give_verdict;
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    step(4);
    t_routes();
    t_channels();
    t_fill();
    t_power();
    give_verdict();
  end
  initial
  begin
    #1000000;
    err_count++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
